/* File: core/irx_receiver.sv */
// Pulse-width receiver with classic Wishbone register slave
//
// Decided for this implementation: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "irx_defines.svh"
module irx_receiver #(
   parameter int CNT_W = 9
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   output logic             wb_err_o,
   input  wire logic        line_i,
   input  wire logic        slow_clk_i,
   output logic             ovf_irq_o
);
   initial begin
      if (CNT_W != 9) $error("irx_receiver: CNT_W must be 9");
   end
   // ****************************************
   // Registers
   // ****************************************
   logic        en_q, adrcmp_q, pol_q, overflow_threshold_select_q, overflow_interrupt_enable_q, ovf_q, start_q;
   logic [1:0]  mode_q;
   logic [7:0]  start_w_q, thr_a_q, thr_b_q;
   logic [4:0]  addr1_q, addr2_q;
   logic [12:0] div_q;
   logic        ack_q;
   logic [31:0] rdat_q;
   logic        wr, rd, hit;
   logic [31:0] word;
   logic [5:0]  nbits;
   assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q;
   assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_q;
   always_comb begin
      hit = 1'b1;
      unique case (wb_adr_i)
         `IRX_OFS_CTRL, `IRX_OFS_STAT, `IRX_OFS_START, `IRX_OFS_THR_LOW,
         `IRX_OFS_THR_HIGH, `IRX_OFS_ADDR1, `IRX_OFS_ADDR2, `IRX_OFS_DATA,
         `IRX_OFS_DIV: hit = 1'b1;
         default: hit = 1'b0;
      endcase
   end
   // ****************************************
   // Bus handshake
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else if (ce_i) begin
         ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
      end
   end
   logic err_q;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         err_q <= 1'b0;
      end else if (ce_i) begin
         err_q <= wb_cyc_i && wb_stb_i && !ack_q && !err_q && !hit;
      end
   end
   assign wb_ack_o = ack_q && !err_q && wb_cyc_i && wb_stb_i;
   assign wb_err_o = err_q && wb_cyc_i && wb_stb_i;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         en_q     <= 1'b0;
         mode_q   <= 2'b00;
         adrcmp_q <= 1'b0;
         pol_q    <= 1'b0;
      end else if (ce_i && wr && wb_sel_i[0] && wb_adr_i == `IRX_OFS_CTRL) begin
         en_q     <= wb_dat_i[`IRX_CTRL_EN];
         mode_q   <= wb_dat_i[`IRX_CTRL_MOD_LO +: 2];
         adrcmp_q <= wb_dat_i[`IRX_CTRL_ADRCMP];
         pol_q    <= wb_dat_i[`IRX_CTRL_POL];
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         start_w_q <= `IRX_RST_BYTE;
         thr_a_q   <= `IRX_RST_BYTE;
         thr_b_q   <= `IRX_RST_BYTE;
         addr1_q   <= 5'h00;
         addr2_q   <= 5'h00;
         overflow_threshold_select_q  <= 1'b0;
         overflow_interrupt_enable_q   <= 1'b0;
      end else if (ce_i && wr && wb_sel_i[0]) begin
         if (wb_adr_i == `IRX_OFS_START) start_w_q <= wb_dat_i[7:0];
         if (wb_adr_i == `IRX_OFS_THR_LOW) thr_a_q <= wb_dat_i[7:0];
         if (wb_adr_i == `IRX_OFS_THR_HIGH) thr_b_q <= wb_dat_i[7:0];
         if (wb_adr_i == `IRX_OFS_ADDR1) addr1_q <= wb_dat_i[4:0];
         if (wb_adr_i == `IRX_OFS_ADDR2) addr2_q <= wb_dat_i[4:0];
         if (wb_adr_i == `IRX_OFS_STAT) begin
            overflow_threshold_select_q <= wb_dat_i[`IRX_STAT_OVERFLOW_THRESHOLD_SELECT];
            overflow_interrupt_enable_q  <= wb_dat_i[`IRX_STAT_OVERFLOW_INTERRUPT_ENABLE];
         end
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_q <= `IRX_RST_DIV;
      end else if (ce_i && wr && wb_adr_i == `IRX_OFS_DIV && wb_sel_i[1:0] == 2'b11) begin
         div_q <= wb_dat_i[12:0];
      end
   end
   // ****************************************
   // Width measurement
   // ****************************************
   logic       tick, lvl, lvl_q, edge_s, ovf_ev, start_ev, bit_ev, bit_val;
   logic [8:0] cnt_q, wid;
   irx_pkg::irx_state_e st_q;
   irx_tick_gen #(.DIV_W(12)) u_tick (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .ce_i       (ce_i),
      .run_i      (en_q),
      .sel_slow_i (div_q[`IRX_DIV_COUNT_CLOCK_SOURCE_SELECT]),
      .divisor_i  (div_q[11:0]),
      .slow_clk_i (slow_clk_i),
      .tick_o     (tick)
   );
   assign lvl    = (mode_q == 2'b00) ? line_i : !line_i;
   assign edge_s = lvl != lvl_q;
   assign wid    = cnt_q;
   always_ff @(posedge clk_i) begin
      if (rst_i || !en_q) begin
         lvl_q <= 1'b0;
         cnt_q <= '0;
      end else if (ce_i) begin
         lvl_q <= lvl;
         if (edge_s) cnt_q <= '0;
         else if (tick && cnt_q != 9'h1FF) cnt_q <= cnt_q + 9'd1;
      end
   end
   assign ovf_ev = en_q && ce_i && st_q == irx_pkg::IRX_ST_BITS && !edge_s && tick &&
                   (cnt_q + 9'd1 == (overflow_threshold_select_q ? `IRX_OVF_LONG : `IRX_OVF_SHORT));
   assign start_ev = en_q && ce_i && st_q == irx_pkg::IRX_ST_START && edge_s && lvl_q &&
                     wid > {1'b0, start_w_q};
   assign bit_ev  = en_q && ce_i && st_q == irx_pkg::IRX_ST_BITS && edge_s && lvl_q &&
                    wid > {1'b0, thr_a_q};
   assign bit_val = (wid < {1'b0, thr_b_q}) ? pol_q : !pol_q;
   always_ff @(posedge clk_i) begin
      if (rst_i || !en_q) begin
         st_q <= irx_pkg::IRX_ST_IDLE;
      end else if (ce_i) begin
         unique case (st_q)
            irx_pkg::IRX_ST_IDLE:  if (!lvl) st_q <= irx_pkg::IRX_ST_START;
            irx_pkg::IRX_ST_START: if (start_ev) st_q <= irx_pkg::IRX_ST_BITS;
            irx_pkg::IRX_ST_BITS:  if (ovf_ev) st_q <= irx_pkg::IRX_ST_IDLE;
            default:               st_q <= irx_pkg::IRX_ST_IDLE;
         endcase
      end
   end
   irx_shift_word #(.WORD_W(32)) u_word (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .ce_i        (ce_i),
      .clear_i     (start_ev),
      .bit_valid_i (bit_ev),
      .bit_i       (bit_val),
      .bus_mode_i  (mode_q == 2'b11),
      .flush_i     (ovf_ev),
      .word_o      (word),
      .nbits_o     (nbits)
   );
   // ****************************************
   // Overflow and start flags
   // ****************************************
   logic addr_ok, ovf_set;
   assign addr_ok = !adrcmp_q || word[28:24] == addr1_q || word[28:24] == addr2_q;
   assign ovf_set = ovf_ev && addr_ok && (mode_q != 2'b00 || nbits >= 6'd16);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ovf_q   <= 1'b0;
         start_q <= 1'b0;
      end else if (ce_i) begin
         if (ovf_set) ovf_q <= 1'b1;
         else if (wr && wb_sel_i[0] && wb_adr_i == `IRX_OFS_STAT && !wb_dat_i[`IRX_STAT_OVF])
            ovf_q <= 1'b0;
         if (start_ev) start_q <= 1'b1;
         else if (wr && wb_sel_i[0] && wb_adr_i == `IRX_OFS_STAT &&
                  !wb_dat_i[`IRX_STAT_START])
            start_q <= 1'b0;
      end
   end
   assign ovf_irq_o = ovf_q && overflow_interrupt_enable_q;
   // ****************************************
   // Read data
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdat_q <= 32'h0000_0000;
      end else if (ce_i && rd) begin
         unique case (wb_adr_i)
            `IRX_OFS_CTRL:     rdat_q <= {24'h0, pol_q, 3'h0, adrcmp_q, mode_q, en_q};
            `IRX_OFS_STAT:     rdat_q <= {26'h0, overflow_interrupt_enable_q, overflow_threshold_select_q, start_q, 2'h0, ovf_q};
            `IRX_OFS_START:    rdat_q <= {24'h0, start_w_q};
            `IRX_OFS_THR_LOW:  rdat_q <= {24'h0, thr_a_q};
            `IRX_OFS_THR_HIGH: rdat_q <= {24'h0, thr_b_q};
            `IRX_OFS_ADDR1:    rdat_q <= {27'h0, addr1_q};
            `IRX_OFS_ADDR2:    rdat_q <= {27'h0, addr2_q};
            `IRX_OFS_DATA:     rdat_q <= word;
            `IRX_OFS_DIV:      rdat_q <= {19'h0, div_q};
            default:           rdat_q <= 32'h0000_0000;
         endcase
      end
   end
   assign wb_dat_o = rdat_q;
endmodule
`default_nettype wire

/* File: core/irx_defines.svh */
// Offsets, field positions, reset values and timing counts for the pulse-width receiver
`ifndef IRX_DEFINES_SVH
`define IRX_DEFINES_SVH
// ****************************************
// Register byte addresses
// ****************************************
`define IRX_OFS_CTRL      8'h00
`define IRX_OFS_STAT      8'h04
`define IRX_OFS_START     8'h08
`define IRX_OFS_THR_LOW   8'h0C
`define IRX_OFS_THR_HIGH  8'h10
`define IRX_OFS_ADDR1     8'h18
`define IRX_OFS_ADDR2     8'h1C
`define IRX_OFS_DATA      8'h20
`define IRX_OFS_DIV       8'h30
// ****************************************
// Field positions
// ****************************************
`define IRX_CTRL_EN       0
`define IRX_CTRL_MOD_LO   1
`define IRX_CTRL_ADRCMP   3
`define IRX_CTRL_POL      7
`define IRX_STAT_OVF      0
`define IRX_STAT_START    3
`define IRX_STAT_OVERFLOW_THRESHOLD_SELECT   4
`define IRX_STAT_OVERFLOW_INTERRUPT_ENABLE    5
`define IRX_DIV_COUNT_CLOCK_SOURCE_SELECT     12
// ****************************************
// Reset values and counts
// ****************************************
`define IRX_RST_BYTE      8'h00
`define IRX_RST_DIV       13'h0000
`define IRX_OVF_SHORT     9'h080
`define IRX_OVF_LONG      9'h100
`endif

/* File: core/irx_pkg.sv */
// Types shared by the pulse-width receiver
package irx_pkg;
   typedef enum logic [1:0] {
      IRX_MODE_IR_FIRST,
      IRX_MODE_FORBIDDEN,
      IRX_MODE_IR_SECOND,
      IRX_MODE_BUS
   } irx_mode_e;
   typedef enum logic [1:0] {
      IRX_ST_IDLE,
      IRX_ST_START,
      IRX_ST_BITS
   } irx_state_e;
endpackage

/* File: core/irx_tick_gen.sv */
// Counting-clock tick generator: divided system clock or sampled slow clock
`timescale 1ns/1ps
`default_nettype none
module irx_tick_gen #(
   parameter int DIV_W = 12
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             ce_i,
   input  wire logic             run_i,
   input  wire logic             sel_slow_i,
   input  wire logic [DIV_W-1:0] divisor_i,
   input  wire logic             slow_clk_i,
   output logic                  tick_o
);
   initial begin
      if (DIV_W < 1 || DIV_W > 16) $error("irx_tick_gen: DIV_W out of range");
   end
   logic [DIV_W-1:0] cnt_q;
   logic             slow_q;
   always_ff @(posedge clk_i) begin
      if (rst_i || !run_i) begin
         cnt_q <= '0;
      end else if (ce_i) begin
         cnt_q <= (cnt_q >= divisor_i) ? '0 : cnt_q + 1'b1;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         slow_q <= 1'b0;
      end else if (ce_i) begin
         slow_q <= slow_clk_i;
      end
   end
   assign tick_o = run_i && ce_i &&
                   (sel_slow_i ? (slow_clk_i && !slow_q) : (cnt_q >= divisor_i));
endmodule
`default_nettype wire

/* File: core/irx_shift_word.sv */
// Receive data word assembler with left-aligned overflow store
`timescale 1ns/1ps
`default_nettype none
module irx_shift_word #(
   parameter int WORD_W = 32
) (
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              ce_i,
   input  wire logic              clear_i,
   input  wire logic              bit_valid_i,
   input  wire logic              bit_i,
   input  wire logic              bus_mode_i,
   input  wire logic              flush_i,
   output logic [WORD_W-1:0]      word_o,
   output logic [5:0]             nbits_o
);
   initial begin
      if (WORD_W != 32) $error("irx_shift_word: WORD_W must be 32");
   end
   logic [WORD_W-1:0] sh_q;
   logic [5:0]        n_q;
   logic [WORD_W-1:0] word_q;
   logic [WORD_W-1:0] sh_d;
   assign sh_d = {sh_q[WORD_W-2:0], bit_i};
   always_ff @(posedge clk_i) begin
      if (rst_i || clear_i) begin
         sh_q <= '0;
         n_q  <= '0;
      end else if (ce_i && bit_valid_i && n_q < 6'd32) begin
         sh_q <= sh_d;
         n_q  <= n_q + 6'd1;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         word_q <= '0;
      end else if (ce_i) begin
         if (bit_valid_i && n_q < 6'd32 && n_q[2:0] == 3'd7) begin
            // bus bytes go to top byte
            if (bus_mode_i) begin
               word_q <= {sh_d[7:0], word_q[23:0]};
            // fill from top byte by byte
            end else begin
               word_q <= sh_d << (5'd24 - {n_q[4:3], 3'b000});
            end
         end else if (flush_i && n_q != 6'd0 && n_q < 6'd32) begin
            word_q <= sh_q << (6'd32 - n_q);
         end
      end
   end
   assign word_o  = word_q;
   assign nbits_o = n_q;
endmodule
`default_nettype wire

/* File: tb/irx_receiver_checker.sv */
// Concurrent checks on the receiver register port and overflow output
`timescale 1ns/1ps
`default_nettype none
`include "irx_defines.svh"
module irx_receiver_checker (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic [31:0] wb_dat_o,
   input  wire logic        wb_ack_o,
   input  wire logic        wb_err_o,
   input  wire logic        line_i,
   input  wire logic        ovf_irq_o
);
   // ****************************************
   // Register port and overflow checks
   // ****************************************
   logic mapped;
   logic rd_ack;
   assign mapped = wb_adr_i inside {`IRX_OFS_CTRL, `IRX_OFS_STAT, `IRX_OFS_START,
      `IRX_OFS_THR_LOW, `IRX_OFS_THR_HIGH, `IRX_OFS_ADDR1, `IRX_OFS_ADDR2,
      `IRX_OFS_DATA, `IRX_OFS_DIV};
   assign rd_ack = wb_ack_o && !wb_we_i;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=>
      wb_ack_o || wb_err_o) else $error("request not answered next cycle");
   a_ack_once: assert property (wb_ack_o || wb_err_o |=> !wb_ack_o && !wb_err_o)
      else $error("answer longer than one cycle");
   a_err_unmapped: assert property (wb_err_o |-> !mapped)
      else $error("error on mapped offset");
   a_ack_mapped: assert property (wb_ack_o |-> mapped)
      else $error("ack on unmapped offset");
   a_addr_high_zero: assert property (rd_ack && (wb_adr_i == `IRX_OFS_ADDR1 ||
      wb_adr_i == `IRX_OFS_ADDR2) |-> wb_dat_o[31:5] == 27'h0000000)
      else $error("address register upper bits set");
   a_div_high_zero: assert property (rd_ack && wb_adr_i == `IRX_OFS_DIV |->
      wb_dat_o[31:13] == 19'h00000) else $error("divider upper bits set");
   a_irq_ie_off: assert property (wb_ack_o && wb_we_i && wb_adr_i == `IRX_OFS_STAT &&
      wb_sel_i[0] && !wb_dat_i[`IRX_STAT_OVERFLOW_INTERRUPT_ENABLE] |=> !ovf_irq_o)
      else $error("overflow irq with enable cleared");
   a_irq_line_quiet: assert property ($rose(ovf_irq_o) && !$past(wb_ack_o) |->
      $past(line_i, 1) == $past(line_i, 120)) else $error("overflow after recent edge");
endmodule
bind irx_receiver irx_receiver_checker u_chk (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .line_i(line_i),
   .ovf_irq_o(ovf_irq_o));
`default_nettype wire

/* File: tb/irx_ir_tx.sv */
// Infrared transmitter model driving the receive line
`timescale 1ns/1ps
`default_nettype none
module irx_ir_tx (
   input  wire logic clk_i,
   input  wire logic inv_i,
   output logic      line_o
);
   logic lvl = 1'b0;
   // active level flips in inverted modes
   assign line_o = lvl ^ inv_i;
   task automatic hold(input logic v, input int n);
      lvl <= v;
      repeat (n) @(posedge clk_i);
   endtask
   // widths scaled to the counting tick
   task automatic frame(input int sw, input int n, input logic [39:0] b, input int k);
      hold(1'b1, sw * k);
      hold(1'b0, 5 * k);
      for (int i = 39; i > 39 - n; i--) begin
         hold(1'b1, (b[i] ? 20 : 10) * k);
         hold(1'b0, 5 * k);
      end
      hold(1'b0, 300 * k);
   endtask
endmodule
`default_nettype wire

/* File: tb/irx_receiver_tb.sv */
// Self-checking bench for the pulse-width receiver
`timescale 1ns/1ps
`default_nettype none
`include "irx_defines.svh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fail_count++; \
   $display("Error %0t: got %h want %h", $time, a, e); end end
module irx_receiver_tb;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        wb_cyc = 1'b0;
   logic        wb_stb = 1'b0;
   logic        wb_we = 1'b0;
   logic [7:0]  wb_adr = 8'h00;
   logic [31:0] wb_dat = 32'h0;
   logic [31:0] rdat;
   logic        wb_ack;
   logic        wb_err;
   logic        line;
   logic        slow_clk = 1'b0;
   logic        inv = 1'b0;
   logic        ovf_irq;
   logic [31:0] rd;
   logic        er;
   logic [39:0] b;
   int          seed = 32'hc103;
   int          fail_count = 0;
   int          cmp_count = 0;
   logic [7:0]  ofs [5] = '{`IRX_OFS_ADDR1, `IRX_OFS_ADDR2, `IRX_OFS_DIV,
                            `IRX_OFS_START, `IRX_OFS_THR_HIGH};
   logic [31:0] msk [5] = '{32'h1F, 32'h1F, 32'h1FFF, 32'hFF, 32'hFF};
   initial forever #25 clk_i = ~clk_i;
   always #15600 slow_clk = ~slow_clk;
   irx_receiver dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(wb_cyc),
      .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF),
      .wb_dat_i(wb_dat), .wb_dat_o(rdat), .wb_ack_o(wb_ack), .wb_err_o(wb_err),
      .line_i(line), .slow_clk_i(slow_clk), .ovf_irq_o(ovf_irq));
   irx_ir_tx tx (.clk_i(clk_i), .inv_i(inv), .line_o(line));
   task automatic complete_run;
      if (fail_count == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= w;
      wb_adr <= a;
      wb_dat <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack !== 1'b1 && wb_err !== 1'b1 && n < 20);
      if (n >= 20) begin
         fail_count++;
         complete_run;
      end
      rd = rdat;
      er = wb_err;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      @(posedge clk_i);
   endtask
   function automatic logic [31:0] exp_word(input int n, input logic [39:0] v);
      exp_word = (n >= 32) ? v[39:8] : v[39:8] & ~(32'hFFFFFFFF >> n);
   endfunction
   task automatic run(input logic [31:0] c, input logic [31:0] dv, input int sw, input int n,
                      input int k, input logic [4:0] am, input logic ei);
      b[39:8] = $random(seed);
      b[7:0] = 8'($random(seed));
      wb(1'b1, `IRX_OFS_CTRL, 32'h0);
      wb(1'b1, `IRX_OFS_STAT, 32'h0);
      wb(1'b1, `IRX_OFS_START, 32'h28);
      wb(1'b1, `IRX_OFS_THR_LOW, 32'h05);
      wb(1'b1, `IRX_OFS_THR_HIGH, 32'h0F);
      wb(1'b1, `IRX_OFS_ADDR1, {27'h0, b[36:32] ^ am});
      wb(1'b1, `IRX_OFS_ADDR2, {27'h0, b[36:32] ^ am});
      wb(1'b1, `IRX_OFS_DIV, dv);
      wb(1'b1, `IRX_OFS_STAT, 32'h20);
      wb(1'b1, `IRX_OFS_CTRL, c);
      tx.frame(sw, n, b, k);
      `CHK(ovf_irq, ei)
      wb(1'b0, `IRX_OFS_DATA, 32'h0);
      if (ei) `CHK(rd, exp_word(n, b))
   endtask
   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      foreach (ofs[i]) begin
         wb(1'b0, ofs[i], 32'h0);
         `CHK(rd, 32'h0)
         wb(1'b1, ofs[i], 32'hFFFF);
         wb(1'b0, ofs[i], 32'h0);
         `CHK(rd, msk[i])
      end
      wb(1'b0, 8'h14, 32'h0);
      `CHK(er, 1'b1)
      `CHK(rd, 32'h0)
      run(32'h9, 32'h0, 50, 24, 1, 5'h00, 1'b1);
      run(32'h1, 32'h0, 50, 8, 1, 5'h00, 1'b0);
      run(32'h9, 32'h0, 50, 24, 1, 5'h1F, 1'b0);
      run(32'h1, 32'h0, 30, 16, 1, 5'h00, 1'b0);
      run(32'h1, 32'h1, 50, 40, 2, 5'h00, 1'b1);
      inv <= 1'b1;
      run(32'h5, 32'h0, 50, 16, 1, 5'h00, 1'b1);
      complete_run;
   end
endmodule
`default_nettype wire
